// file: core/arb_params.svh
// constants for the bus grant handshake block
// What the handshake requires
// (R1) grant rises 1.5 to 3.5 clocks after request
// (R2) request dropped while granted: grant falls in window
// (R3) acknowledge seen: grant falls 1.5 to 3.5 clocks
// (R4) master drops request within 1.5 clocks of acknowledge
// (R5) request held too long: grant may rise again
// (R6) request withdrawn before acknowledge: release grant, drive bus
// (R7) after acknowledge drops, delay control then strobes
// (R8) after withdrawn request, same drive delays apply
// (R9) granted and no cycle: float all buses
// (R10) inputs sampled on falling edges; request early enough
// (R11) acknowledge recognised at first falling edge after setup; the block sees it only at the second, through two flops
// (R12) acknowledge held for tenure; device stays off bus
`ifndef ARB_PARAMS_SVH
`define ARB_PARAMS_SVH
`define CLOCK_PERIOD_NS     10
`define GRANT_DELAY_CYCLES  2'h1
`define FC_DRIVE_CYCLES     2'h1
`define STROBE_DRIVE_CYCLES 2'h2
`endif

// file: core/arb_pkg.sv
// types for the bus grant handshake block
package arb_pkg;
  typedef enum logic [4:0] {
    st_owner   = 5'h01, // device owns bus
    st_wait_g  = 5'h02, // request seen, counting to grant
    st_granted = 5'h04, // grant asserted
    st_drop_g  = 5'h08, // grant negated, settling before handover
    st_tenure  = 5'h10  // other master owns bus
  } arb_state_t;
endpackage

// file: core/fall_sync.sv
// two-stage synchroniser sampling on the falling clock edge
`timescale 1ns/1ns
module fall_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // data
  input  wire logic din,
  output logic      dout
);
  logic meta; // first stage, read only by the second
  // both stages clocked on the falling edge
  always_ff @(negedge clock or negedge nrst) begin
    if (!nrst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// file: core/bus_grant_handshake.sv
// bus grant state machine with bus release and re-drive control
`timescale 1ns/1ns
`include "arb_params.svh"
module bus_grant_handshake (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // arbitration pins, active high internally
  input  wire logic bus_request_in,
  input  wire logic grant_acknowledge_in,
  output logic      bus_grant_out,
  // bus cycle status from the core
  input  wire logic address_strobe,
  // drive enables for the shared bus
  output logic      control_fc_drive,
  output logic      strobe_rw_drive,
  output logic      addr_data_drive,
  // state view
  output arb_pkg::arb_state_t state
);
  import arb_pkg::*;

  logic       req_s;   // synchronised request
  logic       ack_s;   // synchronised acknowledge
  logic [1:0] cnt;     // delay counter
  logic [1:0] rel_cnt; // re-drive counter
  logic       owned;     // someone else may hold the bus
  logic       grant_due; // grant rises at this edge

  // timing sketch, in clocks from a request pin change at a falling edge:
  //   +1.0 first sync stage, +2.0 second stage, +2.5 wait state entered,
  //   +3.5 grant raised, so the grant lands inside the 1.5 to 3.5 window
  //   acknowledge or withdrawal drops the grant 2.5 clocks after the pin
  //   the drive enables come back two and three clocks after release ends
  // hazard: any longer wait would push the grant past the window end
  // limitation: the drive enables are floated on the same edge as the grant,
  //   but only while the core runs no bus cycle of its own

  // states in which the bus belongs to the other side or is being handed over
  function automatic logic hands_off(input arb_state_t s);
    hands_off = (s == st_granted) || (s == st_drop_g) || (s == st_tenure);
  endfunction

  // inputs sampled on falling edges through two flops
  // the pins come from another master with no relation to our clock,
  // so nothing but the second stage of each synchroniser is ever read
  fall_sync u_req (.clock(clock), .nrst(nrst), .din(bus_request_in), .dout(req_s)); // see (R10)
  fall_sync u_ack (.clock(clock), .nrst(nrst), .din(grant_acknowledge_in), .dout(ack_s)); // see (R11)

  // arbitration state machine, one step per rising edge
  // the synchronised inputs change half a clock before each step, so the
  // state always sees a settled request and acknowledge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= st_owner; // device owns the bus out of reset
      cnt   <= 2'h0;
    end else begin
      unique case (state)
        // device drives the bus; a request with no acknowledge opens a round
        st_owner: begin
          if (req_s && !ack_s) begin
            state <= st_wait_g;
            cnt   <= 2'h0;
          end
        end
        // count the wait before the grant, inside the window
        st_wait_g: begin
          if (!req_s) begin
            state <= st_owner; // see (R6)
          end else if (cnt == `GRANT_DELAY_CYCLES - 2'h1) begin
            state <= st_granted; // see (R1)
          end else begin
            cnt <= cnt + 2'h1; // still waiting
          end
        end
        // grant out: withdrawn request or acknowledge both start the release
        st_granted: begin
          if (!req_s || ack_s) begin // see (R2) (R3) (R6)
            state <= st_drop_g;
            cnt   <= 2'h0;
          end
        end
        // grant already low; settle before handing over or taking back
        st_drop_g: begin
          if (cnt == `GRANT_DELAY_CYCLES - 2'h1) begin
            if (ack_s) begin
              state <= st_tenure; // see (R12)
            end else begin
              state <= st_owner; // see (R6)
            end
            cnt <= 2'h0;
          end else begin
            cnt <= cnt + 2'h1; // still settling
          end
        end
        // other master on the bus until its acknowledge drops
        st_tenure: begin
          if (!ack_s) begin
            state <= st_owner; // see (R7)
          end else if (req_s) begin // see (R5)
            state <= st_wait_g; // request held too long: new round
            cnt   <= 2'h0;
          end
        end
        // a broken one-hot code falls back to owning the bus
        default: begin
          state <= st_owner;
          cnt   <= 2'h0;
        end
      endcase
    end
  end

  // grant is due on the last wait cycle while the request still stands
  assign grant_due = (state == st_wait_g) && req_s && (cnt == `GRANT_DELAY_CYCLES - 2'h1); // see (R1)

  // grant output from a flop: raised when due, held only while requested and not acknowledged
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_grant_out <= 1'b0; // no grant out of reset
    end else begin
      bus_grant_out <= grant_due || ((state == st_granted) && req_s && !ack_s); // see (R1) (R2) (R3)
    end
  end

  // bus released from the grant edge on, while handed over or owned by the other master
  assign owned = hands_off(state) || ack_s || grant_due; // see (R9)

  // re-drive delay counter after release ends
  // it saturates at the strobe delay so that a long idle spell cannot wrap it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) rel_cnt <= `STROBE_DRIVE_CYCLES;
    else if (owned) rel_cnt <= 2'h0;
    else if (rel_cnt != `STROBE_DRIVE_CYCLES) rel_cnt <= rel_cnt + 2'h1;
  end

  // drive enables, floated while granted and idle or during tenure
  // a running core cycle keeps the bus driven until its strobe drops or acknowledge is seen,
  // since floating mid-cycle would corrupt the transfer in flight
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      control_fc_drive <= 1'b1;
      strobe_rw_drive  <= 1'b1;
      addr_data_drive  <= 1'b1;
    end else if (owned && (!address_strobe || ack_s)) begin // see (R9) (R12)
      control_fc_drive <= 1'b0;
      strobe_rw_drive  <= 1'b0;
      addr_data_drive  <= 1'b0;
    end else if (!owned) begin
      control_fc_drive <= (rel_cnt >= `FC_DRIVE_CYCLES); // see (R7) (R8)
      strobe_rw_drive  <= (rel_cnt >= `STROBE_DRIVE_CYCLES); // see (R7) (R8)
      addr_data_drive  <= (rel_cnt >= `FC_DRIVE_CYCLES);
    end
  end

  // checks on the handshake; all but the synchroniser ones step on the rising edge

  // strobes not driven while acknowledge held
  no_drive_ack_a: assert property (@(posedge clock) disable iff (!nrst) // see (R12)
    $past(ack_s) && ack_s |-> !strobe_rw_drive) else $error("bus driven during tenure");
  // grant follows request within window
  grant_rise_a: assert property (@(posedge clock) disable iff (!nrst) // see (R1)
    $rose(req_s) && !ack_s && state == st_owner |-> ##[1:4] (bus_grant_out || !req_s))
    else $error("grant late");
  // grant drops after acknowledge
  grant_fall_a: assert property (@(posedge clock) disable iff (!nrst) // see (R3)
    $rose(ack_s) |-> ##[1:4] !bus_grant_out) else $error("grant held after ack");
  // grant drops after request withdrawn
  grant_wd_a: assert property (@(posedge clock) disable iff (!nrst) // see (R2)
    $fell(req_s) && !ack_s |-> ##[1:5] !bus_grant_out) else $error("grant held after withdraw");
  // strobes wait after release
  strobe_wait_a: assert property (@(posedge clock) disable iff (!nrst) // see (R7)
    $fell(owned) |-> !strobe_rw_drive ##1 !strobe_rw_drive) else $error("strobes early");
  // control lines wait after release
  fc_wait_a: assert property (@(posedge clock) disable iff (!nrst) // see (R8)
    $fell(owned) |-> !control_fc_drive) else $error("control early");
  // idle bus floated when granted
  float_idle_a: assert property (@(posedge clock) disable iff (!nrst) // see (R9)
    state == st_granted && !address_strobe |=> !addr_data_drive) else $error("bus not floated");
  // withdrawn request returns ownership
  withdraw_own_a: assert property (@(posedge clock) disable iff (!nrst) // see (R6)
    state == st_wait_g && !req_s |=> state == st_owner) else $error("no return");
  // state register stays one-hot
  state_onehot_a: assert property (@(posedge clock) disable iff (!nrst) // see (R1)
    $onehot(state)) else $error("state not one-hot");
  // grant only ever stands in the granted state
  grant_state_a: assert property (@(posedge clock) disable iff (!nrst) // see (R2)
    bus_grant_out == (state == st_granted)) else $error("grant outside granted state");
  // grant never rises without a request seen a clock earlier
  grant_needs_req_a: assert property (@(posedge clock) disable iff (!nrst) // see (R1)
    $rose(bus_grant_out) |-> $past(req_s)) else $error("grant without request");
  // withdrawn request while granted starts the release
  grant_release_a: assert property (@(posedge clock) disable iff (!nrst) // see (R6)
    state == st_granted && !req_s |=> state == st_drop_g) else $error("release not started");
  // settling without acknowledge hands the bus back
  drop_owner_a: assert property (@(posedge clock) disable iff (!nrst) // see (R6)
    state == st_drop_g && !ack_s |=> state == st_owner) else $error("bus not taken back");
  // tenure ends when acknowledge drops
  tenure_exit_a: assert property (@(posedge clock) disable iff (!nrst) // see (R7)
    state == st_tenure && !ack_s |=> state == st_owner) else $error("tenure not ended");
  // off the bus for the whole tenure
  tenure_float_a: assert property (@(posedge clock) disable iff (!nrst) // see (R12)
    state == st_tenure |-> !addr_data_drive && !control_fc_drive && !strobe_rw_drive)
    else $error("bus driven in tenure");
  // control lines come back no later than strobes
  fc_first_a: assert property (@(posedge clock) disable iff (!nrst) // see (R7)
    strobe_rw_drive |-> control_fc_drive) else $error("strobes before control");
  // strobes return after release ends
  redrive_a: assert property (@(posedge clock) disable iff (!nrst) // see (R6)
    $fell(owned) |-> ##[1:4] (strobe_rw_drive || owned)) else $error("bus not driven again");
  // control lines return after release ends
  fc_return_a: assert property (@(posedge clock) disable iff (!nrst) // see (R7)
    $fell(owned) |-> ##[1:4] (control_fc_drive || owned)) else $error("control not driven again");
  // address and data wait with the control lines
  addr_wait_a: assert property (@(posedge clock) disable iff (!nrst) // see (R8)
    $fell(owned) |-> !addr_data_drive) else $error("address early");
  // idle bus floated on the grant edge
  float_grant_a: assert property (@(posedge clock) disable iff (!nrst) // see (R9)
    $rose(bus_grant_out) && !$past(address_strobe) |-> !addr_data_drive) else $error("float late");
  // acknowledge seen exactly two falling edges after its pin
  ack_sync_a: assert property (@(negedge clock) disable iff (!nrst) // see (R11)
    ack_s == $past(grant_acknowledge_in, 2)) else $error("acknowledge sync skew");
  // request seen exactly two falling edges after its pin
  req_sync_a: assert property (@(negedge clock) disable iff (!nrst) // see (R10)
    req_s == $past(bus_request_in, 2)) else $error("request sync skew");
endmodule

// file: tb/ext_master.sv
// model of the external master that requests, takes and returns the bus
`timescale 1ns/1ns
module ext_master (
  // clock
  input  wire logic clock,
  // commands from the bench
  input  wire logic want,
  input  wire logic take,
  // arbitration pins
  input  wire logic bus_grant_out,
  output logic      bus_request_in,
  output logic      grant_acknowledge_in
);
  // pins idle low at time zero
  initial begin
    bus_request_in = 1'b0;
    grant_acknowledge_in = 1'b0;
  end
  // pins change on falling edges only
  always @(negedge clock) begin
    // acknowledge once granted, held for the whole tenure
    if (take && bus_grant_out) begin
      grant_acknowledge_in <= 1'b1;
    end else if (!take) begin
      grant_acknowledge_in <= 1'b0;
    end
    // request dropped one clock after acknowledge
    bus_request_in <= want && !grant_acknowledge_in;
  end
endmodule

// file: tb/bus_grant_handshake_tb_top.sv
// self-checking bench for the bus grant handshake block
`timescale 1ns/1ns
module bus_grant_handshake_tb_top;
  import arb_pkg::*;
  logic       clock = 1'b0;         // 100 MHz clock
  logic       nrst, want, take;     // reset and master commands
  logic       address_strobe;       // core cycle status, high only in busy_grant
  logic       bus_request_in, grant_acknowledge_in, bus_grant_out;
  logic       control_fc_drive, strobe_rw_drive, addr_data_drive;
  arb_state_t state;                // state view, read by check_state
  int         mismatches = 0;       // failed comparisons
  int         num_checks = 0;       // comparisons made
  int         n;                    // edge count of a measurement
  // free running clock
  always #5 clock = ~clock;
  bus_grant_handshake dut (.clock(clock), .nrst(nrst), .bus_request_in(bus_request_in),
    .grant_acknowledge_in(grant_acknowledge_in), .bus_grant_out(bus_grant_out),
    .address_strobe(address_strobe), .control_fc_drive(control_fc_drive),
    .strobe_rw_drive(strobe_rw_drive), .addr_data_drive(addr_data_drive), .state(state));
  ext_master partner (.clock(clock), .want(want), .take(take), .bus_grant_out(bus_grant_out),
    .bus_request_in(bus_request_in), .grant_acknowledge_in(grant_acknowledge_in));
  // move just past the next falling edge
  task step;
    @(negedge clock);
    #1;
  endtask
  // compare one bit
  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // compare a count of falling edges against a window
  task automatic check_span(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  // compare the state view
  task automatic check_state(input arb_state_t got, input arb_state_t exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // count falling edges until grant shows v; optionally check drives still off after one
  task automatic count_grant(input logic v, input logic off_chk, output int cnt);
    cnt = 0;
    while (bus_grant_out !== v && cnt < 12) begin
      step;
      cnt++;
      if (off_chk && cnt == 1) begin
        check_bit(control_fc_drive, 1'b0);
        check_bit(strobe_rw_drive, 1'b0);
      end
    end
  endtask
  // drives must come back, control lines no later than strobes
  task automatic drive_back;
    int k;
    k = 0;
    while (strobe_rw_drive !== 1'b1 && k < 8) begin
      step;
      k++;
    end
    check_bit(strobe_rw_drive, 1'b1);
    check_bit(control_fc_drive, 1'b1);
    check_bit(addr_data_drive, 1'b1);
    check_state(state, st_owner);
  endtask
  // full tenure: grant, acknowledge, hold, return
  task automatic take_and_return;
    want = 1'b1;
    take = 1'b1;
    while (bus_request_in !== 1'b1) step;
    count_grant(1'b1, 1'b0, n);
    check_span(n, 2, 4);
    check_bit(addr_data_drive, 1'b0);
    count_grant(1'b0, 1'b1, n);
    check_span(n, 2, 4);
    repeat (4) step;
    check_bit(strobe_rw_drive, 1'b0);
    check_bit(bus_grant_out, 1'b0);
    check_state(state, st_tenure);
    take = 1'b0;
    want = 1'b0;
    while (grant_acknowledge_in !== 1'b0) step;
    step;
    check_bit(control_fc_drive, 1'b0);
    check_bit(strobe_rw_drive, 1'b0);
    drive_back;
  endtask
  // request withdrawn before any acknowledge
  task automatic withdraw;
    want = 1'b1;
    while (bus_request_in !== 1'b1) step;
    count_grant(1'b1, 1'b0, n);
    check_span(n, 2, 4);
    want = 1'b0;
    while (bus_request_in !== 1'b0) step;
    count_grant(1'b0, 1'b1, n);
    check_span(n, 2, 4);
    drive_back;
  endtask
  // grant during a core cycle: bus stays driven until the cycle ends
  task automatic busy_grant;
    address_strobe = 1'b1;
    want = 1'b1;
    while (bus_request_in !== 1'b1) step;
    count_grant(1'b1, 1'b0, n);
    check_span(n, 2, 4);
    check_bit(addr_data_drive, 1'b1);
    address_strobe = 1'b0;
    step;
    check_bit(addr_data_drive, 1'b0);
    check_bit(control_fc_drive, 1'b0);
    want = 1'b0;
    while (bus_request_in !== 1'b0) step;
    count_grant(1'b0, 1'b0, n);
    check_span(n, 2, 4);
    drive_back;
  endtask
  // verdict and end of run
  task finish_test;
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    nrst = 1'b0;
    want = 1'b0;
    take = 1'b0;
    address_strobe = 1'b0;
    repeat (8) @(posedge clock);
    step;
    nrst = 1'b1;
    check_bit(bus_grant_out, 1'b0);
    check_bit(strobe_rw_drive, 1'b1);
    check_state(state, st_owner);
    step;
    take_and_return;
    repeat (3) step;
    withdraw;
    repeat (3) step;
    busy_grant;
    finish_test;
  end
  // watchdog against a hang
  initial begin
    #20000;
    mismatches++;
    finish_test;
  end
endmodule
